// ---- include/sync_cfg_pkg.sv ----
// package: constants, register map and field layout of the sync and process-image config bank
package sync_cfg_pkg;

  localparam logic [11:0] OFF_CHAN_COUNT   = 12'h000;
  localparam logic [11:0] OFF_CHAN1_TYPE   = 12'h004;
  localparam logic [11:0] OFF_CHAN2_TYPE   = 12'h008;
  localparam logic [11:0] OFF_CHAN3_TYPE   = 12'h00c;
  localparam logic [11:0] OFF_CHAN4_TYPE   = 12'h010;
  localparam logic [11:0] OFF_OUT_COUNT    = 12'h020;
  localparam logic [11:0] OFF_OUT_SLOT1    = 12'h024;
  localparam logic [11:0] OFF_OUT_SLOT2    = 12'h028;
  localparam logic [11:0] OFF_IN_COUNT     = 12'h030;
  localparam logic [11:0] OFF_IN_SLOT1     = 12'h034;
  localparam logic [11:0] OFF_IN_SLOT2     = 12'h038;
  localparam logic [11:0] OFF_SYNC_COUNT   = 12'h040;
  localparam logic [11:0] OFF_SYNC_MODE    = 12'h044;
  localparam logic [11:0] OFF_CYCLE_TIME   = 12'h048;
  localparam logic [11:0] OFF_SHIFT_TIME   = 12'h04c;
  localparam logic [11:0] OFF_MODES_SUPP   = 12'h050;
  localparam logic [11:0] OFF_MIN_CYCLE    = 12'h054;
  localparam logic [11:0] OFF_MEAS_CMD     = 12'h060;
  localparam logic [11:0] OFF_MEAS_MAX     = 12'h064;

  localparam logic [7:0]  RST_CHAN_COUNT   = 8'h04;
  localparam logic [7:0]  RST_CHAN1_TYPE   = 8'h01;
  localparam logic [7:0]  RST_CHAN2_TYPE   = 8'h02;
  localparam logic [7:0]  RST_CHAN3_TYPE   = 8'h03;
  localparam logic [7:0]  RST_CHAN4_TYPE   = 8'h04;
  localparam logic [7:0]  RST_ASSIGN_COUNT = 8'h01;
  localparam logic [15:0] RST_OUT_SLOT1    = 16'h1602;
  localparam logic [15:0] RST_IN_SLOT1     = 16'h1a02;
  localparam logic [15:0] RST_SLOT2        = 16'h0000;
  localparam logic [7:0]  RST_SYNC_COUNT   = 8'h20;
  localparam logic [15:0] RST_SYNC_MODE    = 16'h0001;
  localparam logic [31:0] RST_CYCLE_TIME   = 32'h0007a120;
  localparam logic [31:0] RST_SHIFT_TIME   = 32'h00000000;
  localparam logic [31:0] RST_MIN_CYCLE    = 32'h00004e20;
  localparam logic [15:0] RST_MEAS_CMD     = 16'h0000;

  // supported-modes field layout
  localparam int          POS_FREE_RUN     = 0;
  localparam int          POS_SM_EVENT     = 1;
  localparam int          POS_DC_LO        = 2;
  localparam int          POS_SHIFT_LO     = 4;
  localparam int          POS_DYNAMIC      = 14;
  localparam logic [1:0]  DC_SUPPORT_CODE  = 2'h1;
  localparam logic [1:0]  SHIFT_SYNC2_CODE = 2'h2;
  localparam logic [15:0] RST_MODES_SUPP   = 16'hc007;

  // clock period in ns, for converting measured cycles to nanoseconds
  localparam logic [31:0] CLK_PERIOD_NS    = 32'h00000064;

  typedef enum logic [1:0] {
    MODE_FREE_RUN = 2'h0,
    MODE_SM_EVENT = 2'h1,
    MODE_SECOND_SYNC_PULSE    = 2'h2,
    MODE_SYNC2    = 2'h3
  } sync_mode_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

endpackage : sync_cfg_pkg

// ---- hdl/sync_cfg_bank.sv ----
// sync-channel and process-image configuration bank behind an APB slave
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module sync_cfg_bank (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire sync_cfg_pkg::apb_req_s apbReq,
  input  wire logic                   cycleTick,
  output var  sync_cfg_pkg::apb_rsp_s apbRsp,
  output logic [1:0]                  syncMode,
  output logic [31:0]                 cycleTime,
  output logic                        measuring
);
  import sync_cfg_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_ARM  = 3'b010,
    ST_RUN  = 3'b100
  } meas_e;

  logic [7:0]  outCount;
  logic [15:0] outSlot1;
  logic [15:0] outSlot2;
  logic [7:0]  inCount;
  logic [15:0] inSlot1;
  logic [15:0] inSlot2;
  logic [15:0] modeWord;
  logic [31:0] cycleWord;
  logic [15:0] measCmd;
  logic [31:0] measMax;
  logic [31:0] measCnt;
  logic        tickS1;
  logic        tickS2;
  logic        tickS3;
  logic        tickSeen;
  logic        tickEdge;
  logic        wrEn;
  logic        rdEn;
  logic [31:0] rdData;
  logic        hit;
  logic [15:0] modesSupp;
  meas_e       measState;
  meas_e       next_measState;
  logic        selOutCount;
  logic        selOutSlot1;
  logic        selOutSlot2;
  logic        selInCount;
  logic        selInSlot1;
  logic        selInSlot2;
  logic        selSyncMode;
  logic        selCycleTime;
  logic        selMeasCmd;
  logic        setupPh;
  logic [7:0]  chanType [4];

  assign wrEn    = apbReq.psel & apbReq.penable & apbReq.pwrite;
  assign rdEn    = apbReq.psel & ~apbReq.penable & ~apbReq.pwrite;
  assign setupPh = apbReq.psel & ~apbReq.penable;

  // one write strobe per writable entry; read-only and unmapped offsets get none
  assign selOutCount  = wrEn & (apbReq.paddr == OFF_OUT_COUNT);
  assign selOutSlot1  = wrEn & (apbReq.paddr == OFF_OUT_SLOT1);
  assign selOutSlot2  = wrEn & (apbReq.paddr == OFF_OUT_SLOT2);
  assign selInCount   = wrEn & (apbReq.paddr == OFF_IN_COUNT);
  assign selInSlot1   = wrEn & (apbReq.paddr == OFF_IN_SLOT1);
  assign selInSlot2   = wrEn & (apbReq.paddr == OFF_IN_SLOT2);
  assign selSyncMode  = wrEn & (apbReq.paddr == OFF_SYNC_MODE);
  assign selCycleTime = wrEn & (apbReq.paddr == OFF_CYCLE_TIME);
  assign selMeasCmd   = wrEn & (apbReq.paddr == OFF_MEAS_CMD);

  // constant word; the fixed word value governs the shift field, which reads clear
  always_comb
  begin
    modesSupp = '0;
    modesSupp[POS_FREE_RUN] = 1'b1;
    modesSupp[POS_SM_EVENT] = 1'b1;
    modesSupp[POS_DC_LO +: 2] = DC_SUPPORT_CODE;
    modesSupp[POS_SHIFT_LO +: 2] = RST_MODES_SUPP[POS_SHIFT_LO +: 2];
    modesSupp[POS_DYNAMIC] = 1'b1;
    modesSupp[15] = RST_MODES_SUPP[15];
  end

  // one fixed type code per sync channel; no write can reach them
  generate
    for (genvar ch = 0; ch < 4; ch++)
    begin : g_chan
      assign chanType[ch] = (ch == 0) ? RST_CHAN1_TYPE :
                            (ch == 1) ? RST_CHAN2_TYPE :
                            (ch == 2) ? RST_CHAN3_TYPE :
                                        RST_CHAN4_TYPE;
    end
  endgenerate

  // writable entries keep their defaults until a completed write reaches them
  // output assignment list
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      outCount <= RST_ASSIGN_COUNT;
    end
    else if (selOutCount)
    begin
      outCount <= apbReq.pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      outSlot1 <= RST_OUT_SLOT1;
    end
    else if (selOutSlot1)
    begin
      outSlot1 <= apbReq.pwdata[15:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      outSlot2 <= RST_SLOT2;
    end
    else if (selOutSlot2)
    begin
      outSlot2 <= apbReq.pwdata[15:0];
    end
  end

  // input assignment list
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      inCount <= RST_ASSIGN_COUNT;
    end
    else if (selInCount)
    begin
      inCount <= apbReq.pwdata[7:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      inSlot1 <= RST_IN_SLOT1;
    end
    else if (selInSlot1)
    begin
      inSlot1 <= apbReq.pwdata[15:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      inSlot2 <= RST_SLOT2;
    end
    else if (selInSlot2)
    begin
      inSlot2 <= apbReq.pwdata[15:0];
    end
  end

  // output sync parameters
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      modeWord <= RST_SYNC_MODE;
    end
    else if (selSyncMode)
    begin
      modeWord <= apbReq.pwdata[15:0];
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cycleWord <= RST_CYCLE_TIME;
    end
    else if (selCycleTime)
    begin
      cycleWord <= apbReq.pwdata;
    end
  end

  // measurement command: stored as written, decoded by the sequencer below
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      measCmd <= RST_MEAS_CMD;
    end
    else if (selMeasCmd)
    begin
      measCmd <= apbReq.pwdata[15:0];
    end
  end

  // steering outputs: the mode code and period the sync logic obeys
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      syncMode <= MODE_SM_EVENT;
    else
      syncMode <= modeWord[1:0];
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      cycleTime <= RST_CYCLE_TIME;
    else
      cycleTime <= cycleWord;
  end

  // cycle tick is external: three stages, edge once stages two and three agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tickS1 <= 1'b0;
      tickS2 <= 1'b0;
      tickS3 <= 1'b0;
    end
    else
    begin
      tickS1 <= cycleTick;
      tickS2 <= tickS1;
      tickS3 <= tickS2;
    end
  end

  // settled level: follows the pin only while stages two and three agree
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      tickSeen <= 1'b0;
    else if (tickS2 == tickS3)
      tickSeen <= tickS3;
  end

  assign tickEdge = (tickS2 == tickS3) & tickS3 & ~tickSeen;

  always_comb
  begin
    next_measState = measState;
    case (measState)
      ST_IDLE: if (measCmd == 16'h0001) next_measState = ST_ARM;
      ST_ARM:  if (tickEdge) next_measState = ST_RUN;
      ST_RUN:  if (measCmd == 16'h0000) next_measState = ST_IDLE;
      default: next_measState = ST_IDLE;
    endcase
    // a stop command wins from any state
    if (measState != ST_IDLE && measCmd == 16'h0000)
      next_measState = ST_IDLE;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      measState <= ST_IDLE;
    else
      measState <= next_measState;
  end

  // maximum survives a stop so software can read it; cleared on the next start
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      measCnt <= '0;
      measMax <= '0;
    end
    else if (measState == ST_IDLE && next_measState == ST_ARM)
    begin
      measCnt <= '0;
      measMax <= '0;
    end
    else if (measState == ST_RUN)
    begin
      if (tickEdge)
      begin
        measCnt <= '0;
        if (measCnt + 32'h1 > measMax)
          measMax <= measCnt + 32'h1;
      end
      else
        measCnt <= measCnt + 32'h1;
    end
    else if (measState == ST_ARM)
      measCnt <= '0;
  end

  // taken from the next state so the flag changes together with the state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      measuring <= 1'b0;
    else
      measuring <= (next_measState != ST_IDLE);
  end

  // read decode: narrow entries return zero in the unused upper bits
  always_comb
  begin
    rdData = '0;
    hit    = 1'b1;
    case (apbReq.paddr)
      OFF_CHAN_COUNT: rdData[7:0]  = RST_CHAN_COUNT;
      OFF_CHAN1_TYPE: rdData[7:0]  = chanType[0];
      OFF_CHAN2_TYPE: rdData[7:0]  = chanType[1];
      OFF_CHAN3_TYPE: rdData[7:0]  = chanType[2];
      OFF_CHAN4_TYPE: rdData[7:0]  = chanType[3];
      OFF_OUT_COUNT:  rdData[7:0]  = outCount;
      OFF_OUT_SLOT1:  rdData[15:0] = outSlot1;
      OFF_OUT_SLOT2:  rdData[15:0] = outSlot2;
      OFF_IN_COUNT:   rdData[7:0]  = inCount;
      OFF_IN_SLOT1:   rdData[15:0] = inSlot1;
      OFF_IN_SLOT2:   rdData[15:0] = inSlot2;
      OFF_SYNC_COUNT: rdData[7:0]  = RST_SYNC_COUNT;
      OFF_SYNC_MODE:  rdData[15:0] = modeWord;
      OFF_CYCLE_TIME: rdData       = cycleWord;
      OFF_SHIFT_TIME: rdData       = RST_SHIFT_TIME;
      OFF_MODES_SUPP: rdData[15:0] = modesSupp;
      OFF_MIN_CYCLE:  rdData       = RST_MIN_CYCLE;
      OFF_MEAS_CMD:   rdData[15:0] = measCmd;
      OFF_MEAS_MAX:   rdData       = 32'(measMax * CLK_PERIOD_NS);
      default:        hit          = 1'b0;
    endcase
  end

  // zero-wait slave: ready, error and read data are registered in the setup
  // cycle, so each stands for the access cycle alone and then falls to zero
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      apbRsp <= '0;
    else
    begin
      apbRsp.pready  <= setupPh;
      apbRsp.pslverr <= setupPh & ~hit;
      apbRsp.prdata  <= rdEn ? rdData : 32'h00000000;
    end
  end

endmodule : sync_cfg_bank
`default_nettype wire

// ---- testbench/tick_source.sv ----
// local-cycle tick source standing in for the terminal's cycle timer
`timescale 1ns/1ps
`default_nettype none
module tick_source #(
  parameter int PERIOD = 10
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic run,
  output logic      cycleTick
);
  int cnt;

  // ticks only while run is high, so a stopped measurement sees no edges
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cnt       <= 0;
      cycleTick <= 1'b0;
    end
    else if (run)
    begin
      cnt       <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      cycleTick <= (cnt < PERIOD / 2);
    end
  end
endmodule : tick_source
`default_nettype wire

// ---- testbench/sync_cfg_properties.sv ----
// port-level assertions for the sync and process-image config bank
`timescale 1ns/1ps
`default_nettype none
module sync_cfg_properties (
  input wire logic                   clk,
  input wire logic                   rst,
  input wire sync_cfg_pkg::apb_req_s apbReq,
  input wire logic                   cycleTick,
  input wire sync_cfg_pkg::apb_rsp_s apbRsp,
  input wire logic [1:0]             syncMode,
  input wire logic [31:0]            cycleTime,
  input wire logic                   measuring
);
  import sync_cfg_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic setup;
  logic wrSetup;
  logic rdSetup;
  assign setup   = apbReq.psel && !apbReq.penable;
  assign wrSetup = setup && apbReq.pwrite;
  assign rdSetup = setup && !apbReq.pwrite;

  a_ready_after_setup: assert property (setup |=> apbRsp.pready)
    else $error("no ready after setup");
  a_ready_single: assert property (apbRsp.pready |=> !apbRsp.pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
    else $error("error without ready");
  a_idle_data_zero: assert property (!apbRsp.pready |-> apbRsp.prdata == 32'h0)
    else $error("read data outside access");
  a_count_reads_four: assert property (
    rdSetup && apbReq.paddr == OFF_CHAN_COUNT |=> apbRsp.prdata == 32'h00000004)
    else $error("channel count wrong");
  a_modes_word: assert property (
    rdSetup && apbReq.paddr == OFF_MODES_SUPP |=> apbRsp.prdata == 32'h0000c007)
    else $error("supported modes wrong");
  a_mode_follows_write: assert property (
    wrSetup && apbReq.paddr == OFF_SYNC_MODE |-> ##3 syncMode == $past(apbReq.pwdata[1:0], 3))
    else $error("sync mode output stale");
  a_cycle_follows_write: assert property (
    wrSetup && apbReq.paddr == OFF_CYCLE_TIME |-> ##3 cycleTime == $past(apbReq.pwdata, 3))
    else $error("cycle time output stale");
  a_meas_armed: assert property (
    wrSetup && apbReq.paddr == OFF_MEAS_CMD && apbReq.pwdata == 32'h1 |-> ##[1:3] measuring)
    else $error("measurement not armed");
  a_meas_stopped: assert property (
    wrSetup && apbReq.paddr == OFF_MEAS_CMD && apbReq.pwdata == 32'h0 |-> ##[1:3] !measuring)
    else $error("measurement not stopped");
endmodule : sync_cfg_properties

bind sync_cfg_bank sync_cfg_properties sync_cfg_properties_i (
  .clk(clk), .rst(rst), .apbReq(apbReq), .cycleTick(cycleTick), .apbRsp(apbRsp),
  .syncMode(syncMode), .cycleTime(cycleTime), .measuring(measuring));
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench: APB register tests of the config bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sync_cfg_pkg::*;
  logic        clk;
  logic        rst;
  logic        run;
  logic        tick;
  apb_req_s    req;
  apb_rsp_s    rsp;
  logic [1:0]  syncMode;
  logic [31:0] cycleTime;
  logic        measuring;
  logic [31:0] rdat;
  logic        rerr;
  int          err_count = 0;
  int          check_count = 0;
  int          cyc = 0;

  sync_cfg_bank sync_cfg_bank_i (.clk(clk), .rst(rst), .apbReq(req), .cycleTick(tick),
    .apbRsp(rsp), .syncMode(syncMode), .cycleTime(cycleTime), .measuring(measuring));
  tick_source #(.PERIOD(10)) tick_source_i (.clk(clk), .rst(rst), .run(run), .cycleTick(tick));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task stop_test;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  // a hung access would otherwise stall the run forever
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 8000)
    begin
      err_count++;
      stop_test();
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one idle edge after release keeps psel from being assigned twice in a step
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do
      @(posedge clk);
    while (rsp.pready !== 1'b1);
    rdat = rsp.prdata;
    rerr = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask : xfer

  task rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd

  task ro(input logic [11:0] a, input logic [31:0] exp);
    rd(a, exp);
    xfer(1'b1, a, 32'hffffffff);
    rd(a, exp);
  endtask : ro

  task rw(input logic [11:0] a, input logic [31:0] def, input logic [31:0] w,
          input logic [31:0] exp);
    rd(a, def);
    xfer(1'b1, a, w);
    rd(a, exp);
  endtask : rw

  initial
  begin
    rst = 1'b1;
    run = 1'b0;
    req = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk({30'h0, syncMode}, 32'h1);
    chk(cycleTime, 32'h0007a120);
    ro(OFF_CHAN_COUNT, 32'h4);
    ro(OFF_CHAN1_TYPE, 32'h1);
    ro(OFF_CHAN2_TYPE, 32'h2);
    ro(OFF_CHAN3_TYPE, 32'h3);
    ro(OFF_CHAN4_TYPE, 32'h4);
    ro(OFF_SYNC_COUNT, 32'h20);
    ro(OFF_SHIFT_TIME, 32'h0);
    ro(OFF_MODES_SUPP, 32'hc007);
    ro(OFF_MIN_CYCLE, 32'h4e20);
    rw(OFF_OUT_COUNT, 32'h1, 32'hffffffff, 32'hff);
    rw(OFF_OUT_SLOT1, 32'h1602, 32'h12345678, 32'h5678);
    rw(OFF_OUT_SLOT2, 32'h0, 32'h1603, 32'h1603);
    rw(OFF_IN_COUNT, 32'h1, 32'h2, 32'h2);
    rw(OFF_IN_SLOT1, 32'h1a02, 32'hffff1a03, 32'h1a03);
    rw(OFF_IN_SLOT2, 32'h0, 32'h1a04, 32'h1a04);
    rw(OFF_CYCLE_TIME, 32'h0007a120, 32'h4e20, 32'h4e20);
    chk(cycleTime, 32'h4e20);
    rd(OFF_SYNC_MODE, 32'h1);
    for (int k = 3; k >= 0; k--)
    begin
      xfer(1'b1, OFF_SYNC_MODE, 32'(k));
      @(posedge clk);
      chk({30'h0, syncMode}, 32'(k));
    end
    xfer(1'b1, 12'h0fc, 32'h1);
    chk({31'h0, rerr}, 32'h1);
    rd(OFF_MEAS_CMD, 32'h0);
    run <= 1'b1;
    xfer(1'b1, OFF_MEAS_CMD, 32'h1);
    @(posedge clk);
    chk({31'h0, measuring}, 32'h1);
    repeat (60) @(posedge clk);
    xfer(1'b1, OFF_MEAS_CMD, 32'h0);
    run <= 1'b0;
    @(posedge clk);
    chk({31'h0, measuring}, 32'h0);
    rd(OFF_MEAS_MAX, 32'h3e8);
    xfer(1'b1, OFF_MEAS_CMD, 32'h1);
    rd(OFF_MEAS_MAX, 32'h0);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
